// file: hw/pla_pkg.sv
// package of register map, field positions and timing for the life alarm monitor
// assumes a 125 MHz single clock and an Avalon-MM register slave
package pla_pkg;
  // ------------------------------------------------------------
  // register word addresses (byte address = 4 * index)
  // ------------------------------------------------------------
  localparam logic [3:0] REG_FLAGS      = 4'h0;
  localparam logic [3:0] REG_INRUSH     = 4'h1;
  localparam logic [3:0] REG_CTRL_CAP   = 4'h2;
  localparam logic [3:0] REG_MAIN_CAP   = 4'h3;
  localparam logic [3:0] REG_MEAS_STATE = 4'h4;
  localparam logic [3:0] REG_OUT_SEL    = 4'h5;
  localparam logic [3:0] REG_IRQ_STAT   = 4'h6;
  localparam logic [3:0] REG_IRQ_MASK   = 4'h7;
  localparam logic [3:0] REG_MAIN_MEAS  = 4'h8;
  localparam logic [3:0] REG_REPLACE    = 4'h9;
  // ------------------------------------------------------------
  // flag bit positions
  // ------------------------------------------------------------
  localparam int BIT_CTRL_CAP = 0;
  localparam int BIT_MAIN_CAP = 1;
  localparam int BIT_FAN      = 2;
  localparam int BIT_INRUSH   = 3;
  // ------------------------------------------------------------
  // life figures in percent
  // ------------------------------------------------------------
  localparam logic [6:0] LIFE_FULL       = 7'h64; // 100 %
  localparam logic [6:0] INRUSH_ALARM    = 7'h0A; // 10 %
  localparam logic [6:0] CTRL_CAP_ALARM  = 7'h0A; // below 10 %
  localparam logic [6:0] MAIN_CAP_ALARM  = 7'h55; // 85 % or lower
  localparam int         INRUSH_PER_PCT  = 10000;
  // ------------------------------------------------------------
  // terminal function codes
  // ------------------------------------------------------------
  localparam logic [7:0] SEL_POS = 8'h5A;          // 90
  localparam logic [7:0] SEL_NEG = 8'hBE;          // 190
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_HZ       = 125000000;
  localparam int DC_APPLY_MS  = 1000;              // dc voltage for 1 s
  localparam int DC_APPLY_CYC = (CLK_HZ / 1000) * DC_APPLY_MS;
  // ------------------------------------------------------------
  // measurement state codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    MS_IDLE  = 4'h0,
    MS_START = 4'h1,
    MS_RUN   = 4'h2,
    MS_DONE  = 4'h3,
    MS_FORCE = 4'h8,
    MS_ERR   = 4'h9
  } pla_meas_t;
endpackage

// file: hw/pla_monitor.sv
// life alarm monitor: part wear counters, alarm flags, capacitor measure sequence
// assumes single clk at 125 MHz, async active-low rstn, external pins synced here
//
// Contract
// - four-bit flag word: bit3 inrush, bit2 fan, bit1 main cap, bit0 ctrl cap.
// - combined alarm is on whenever any flag bit is set; the terminal shows it only for select code 90 or 190, else low.
// - terminal select code 90 drives alarm true, 190 drives it inverted.
// - inrush life counts down one percent per ten thousand contact closures.
// - inrush life at 10 percent sets bit3 and the alarm.
// - control capacitor life counts down from 100 percent while operating.
// - control capacitor life below 10 percent sets bit0 and the alarm.
// - main capacitor life updates only when a measurement completes.
// - measured main life 85 percent or lower sets bit1 and the alarm.
// - state codes 0,1,2,3,8,9; only 0 and 1 are writable.
// - start requested begins measurement at power-off, dc applied for one second.
// - early power return may leave state 2; host repeats from start request (a write of 1 is ignored while the state is 2).
// - run command or shutoff during measuring gives 8, a measurement fault at the dc end gives 9.
// - fan speed at half or less sets bit2, alarm and fan fault indication.
// - any single worn fan among several raises the fan alarm.
module pla_monitor #(
  parameter int N_FANS       = 2,
  parameter int DC_CYCLES    = pla_pkg::DC_APPLY_CYC,
  parameter int CTRL_AGE_CYC = 125000000
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic [3:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  input  wire logic              contact_on,
  input  wire logic              operating,
  input  wire logic              hot,
  input  wire logic [N_FANS-1:0] fan_slow,
  input  wire logic              power_off,
  input  wire logic              run_cmd,
  input  wire logic              output_shutoff_input,
  input  wire logic              meas_fault,
  output logic                   dc_apply,
  output logic                   life_alarm_out,
  output logic                   fan_fault_indication,
  output logic                   irq
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  // fan pins on top, single pins below
  localparam int NP = N_FANS + 7;
  logic [NP-1:0] pin_a_r;
  logic [NP-1:0] pin_b_r;
  wire  [NP-1:0] pin_raw = {fan_slow, contact_on, operating, hot, power_off,
                            run_cmd, output_shutoff_input, meas_fault};
  // two flops per pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_a_r <= '0;
      pin_b_r <= '0;
    end else begin
      pin_a_r <= pin_raw;
      pin_b_r <= pin_a_r;
    end
  end
  // synced pin views, only the second flop is read
  wire [N_FANS-1:0] fan_s   = pin_b_r[NP-1:7];
  wire              cont_s  = pin_b_r[6];
  wire              oper_s  = pin_b_r[5];
  wire              hot_s   = pin_b_r[4];
  wire              poff_s  = pin_b_r[3];
  wire              run_s   = pin_b_r[2];
  wire              shut_s  = pin_b_r[1];
  wire              mfault_s = pin_b_r[0];

  // ------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------
  // address match, shared by every write strobe
  function automatic logic reg_hit(input logic [3:0] addr,
                                   input logic [3:0] idx);
    return addr == idx;
  endfunction
  // acc takes a request, wr lands a write on the edge waitrequest is low
  logic        ack_r;
  wire         acc     = (avs_read | avs_write) & ~ack_r;
  wire         wr      = avs_write & ack_r;
  wire         wr_meas = wr & reg_hit(avs_address, pla_pkg::REG_MEAS_STATE);
  wire         wr_sel  = wr & reg_hit(avs_address, pla_pkg::REG_OUT_SEL);
  wire         wr_ist  = wr & reg_hit(avs_address, pla_pkg::REG_IRQ_STAT);
  wire         wr_imsk = wr & reg_hit(avs_address, pla_pkg::REG_IRQ_MASK);
  wire         wr_mval = wr & reg_hit(avs_address, pla_pkg::REG_MAIN_MEAS);
  wire         wr_repl = wr & reg_hit(avs_address, pla_pkg::REG_REPLACE);
  wire [3:0]   repl    = wr_repl ? avs_writedata[3:0] : 4'h0;

  // ------------------------------------------------------------
  // inrush contact counter
  // ------------------------------------------------------------
  // closure counter, inrush life and contact edge detect
  logic [13:0] cont_cnt_r;
  logic [6:0]  inrush_life_r;
  logic        cont_d_r;
  wire         cont_edge    = cont_s & ~cont_d_r;
  wire         pct_step     = cont_edge & (cont_cnt_r == 14'(pla_pkg::INRUSH_PER_PCT - 1));
  wire  [13:0] cont_cnt_nxt = pct_step ? 14'h0000 : cont_cnt_r + 14'h0001;
  // delayed contact level for the closure edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cont_d_r <= 1'b0;
    end else begin
      cont_d_r <= cont_s;
    end
  end
  // count closures, drop one percent per block
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cont_cnt_r    <= 14'h0000;
      inrush_life_r <= pla_pkg::LIFE_FULL;
    end else begin
      if (repl[pla_pkg::BIT_INRUSH]) begin
        cont_cnt_r    <= 14'h0000;
        inrush_life_r <= pla_pkg::LIFE_FULL;
      end else if (cont_edge) begin
        cont_cnt_r <= cont_cnt_nxt;
        if (pct_step && inrush_life_r != 7'h00)
          inrush_life_r <= inrush_life_r - 7'h01;
      end
    end
  end

  // ------------------------------------------------------------
  // control capacitor ageing
  // ------------------------------------------------------------
  // ageing accumulator and control capacitor life
  logic [31:0] age_cnt_r;
  logic [6:0]  ctrl_life_r;
  wire  [31:0] age_inc     = hot_s ? 32'h0000_0002 : 32'h0000_0001;
  wire         age_step    = oper_s & (age_cnt_r + age_inc >= 32'(CTRL_AGE_CYC));
  wire  [31:0] age_cnt_nxt = age_step ? 32'h0000_0000 : age_cnt_r + age_inc;
  // hot operation ages twice as fast
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      age_cnt_r   <= 32'h0000_0000;
      ctrl_life_r <= pla_pkg::LIFE_FULL;
    end else if (repl[pla_pkg::BIT_CTRL_CAP]) begin
      age_cnt_r   <= 32'h0000_0000;
      ctrl_life_r <= pla_pkg::LIFE_FULL;
    end else if (oper_s) begin
      age_cnt_r <= age_cnt_nxt;
      if (age_step && ctrl_life_r != 7'h00)
        ctrl_life_r <= ctrl_life_r - 7'h01;
    end
  end

  // ------------------------------------------------------------
  // main capacitor measurement sequence
  // ------------------------------------------------------------
  // measurement state, dc timer and capacitor values
  pla_pkg::pla_meas_t ms_r;
  pla_pkg::pla_meas_t ms_nxt;
  logic [31:0] dc_cnt_r;
  logic [6:0]  main_meas_r;
  logic [6:0]  main_life_r;
  logic        poff_d_r;
  wire         pon_edge = ~poff_s & poff_d_r;
  wire         poff_edge = poff_s & ~poff_d_r;
  wire         dc_end   = (dc_cnt_r == 32'(DC_CYCLES - 1));
  wire         disturb  = run_s | shut_s;
  wire [3:0]   wcode    = avs_writedata[3:0];
  wire         meas_ok  = (ms_r == pla_pkg::MS_RUN) & dc_end & ~disturb & ~mfault_s;
  // next state of the measurement
  always_comb begin
    ms_nxt = ms_r;
    unique case (ms_r)
      pla_pkg::MS_START: begin
        if (poff_edge) ms_nxt = pla_pkg::MS_RUN;
      end
      pla_pkg::MS_RUN: begin
        if (disturb) ms_nxt = pla_pkg::MS_FORCE;
        else if (pon_edge) ms_nxt = pla_pkg::MS_RUN;
        else if (dc_end) ms_nxt = mfault_s ? pla_pkg::MS_ERR : pla_pkg::MS_DONE;
      end
      default: ;
    endcase
    // only idle and start requested may be written
    if (wr_meas && (wcode == 4'h0 || wcode == 4'h1) && ms_r != pla_pkg::MS_RUN)
      ms_nxt = pla_pkg::pla_meas_t'(wcode);
  end
  // dc timer runs only while measuring with power off
  wire  [31:0] dc_cnt_nxt   = (ms_r == pla_pkg::MS_RUN && poff_s && !dc_end) ?
                              dc_cnt_r + 32'h0000_0001 : 32'h0000_0000;
  wire         dc_apply_nxt = (ms_nxt == pla_pkg::MS_RUN) & poff_s;
  // state and power edge register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ms_r     <= pla_pkg::MS_IDLE;
      poff_d_r <= 1'b0;
    end else begin
      ms_r     <= ms_nxt;
      poff_d_r <= poff_s;
    end
  end
  // dc timer and dc drive to the motor
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dc_cnt_r <= 32'h0000_0000;
      dc_apply <= 1'b0;
    end else begin
      dc_cnt_r <= dc_cnt_nxt;
      dc_apply <= dc_apply_nxt;
    end
  end
  // measured value stands in for the analogue result, copied on success
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      main_meas_r <= pla_pkg::LIFE_FULL;
      main_life_r <= pla_pkg::LIFE_FULL;
    end else begin
      if (wr_mval) main_meas_r <= avs_writedata[6:0];
      if (meas_ok) main_life_r <= main_meas_r;
    end
  end

  // ------------------------------------------------------------
  // alarm flags, hold until replacement (main cap also a passing measurement) in a cycle whose set term is low
  // ------------------------------------------------------------
  // flag word, set and clear terms, terminal select
  logic [3:0] flags_r;
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  logic [7:0] out_sel_r;
  logic       fan_worn;
  assign fan_worn = |fan_s;
  always_comb begin
    flag_set = 4'h0;
    flag_set[pla_pkg::BIT_INRUSH]   = inrush_life_r <= pla_pkg::INRUSH_ALARM;
    flag_set[pla_pkg::BIT_FAN]      = fan_worn;
    flag_set[pla_pkg::BIT_MAIN_CAP] = main_life_r <= pla_pkg::MAIN_CAP_ALARM;
    flag_set[pla_pkg::BIT_CTRL_CAP] = ctrl_life_r < pla_pkg::CTRL_CAP_ALARM;
    flag_clr = repl;
    flag_clr[pla_pkg::BIT_MAIN_CAP] = repl[pla_pkg::BIT_MAIN_CAP] |
                                      (meas_ok & (main_meas_r > pla_pkg::MAIN_CAP_ALARM));
  end
  // set wins over clear
  wire [3:0] flags_nxt = (flags_r & ~flag_clr) | flag_set;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      flags_r <= 4'h0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs and terminal mapping
  // ------------------------------------------------------------
  // any flag drives the alarm; select code picks the terminal sense
  wire any_alarm = |flags_r;
  wire term_nxt  = (out_sel_r == pla_pkg::SEL_POS) ? any_alarm :
                   (out_sel_r == pla_pkg::SEL_NEG) ? ~any_alarm : 1'b0;
  // terminal function select register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      out_sel_r <= 8'h00;
    end else if (wr_sel) begin
      out_sel_r <= avs_writedata[7:0];
    end
  end
  // registered alarm and fan fault outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      life_alarm_out       <= 1'b0;
      fan_fault_indication <= 1'b0;
    end else begin
      fan_fault_indication <= flags_r[pla_pkg::BIT_FAN];
      life_alarm_out       <= term_nxt;
    end
  end

  // ------------------------------------------------------------
  // interrupts: sticky on rising flags, write one to clear
  // ------------------------------------------------------------
  // status, mask and flag history for edge detect
  logic [3:0] ist_r;
  logic [3:0] imsk_r;
  logic [3:0] flags_d_r;
  wire  [3:0] ev      = flags_r & ~flags_d_r;
  wire  [3:0] w1c     = wr_ist ? avs_writedata[3:0] : 4'h0;
  wire  [3:0] ist_nxt = (ist_r & ~w1c) | ev;                // event wins over clear
  // interrupt mask register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      imsk_r <= 4'h0;
    end else if (wr_imsk) begin
      imsk_r <= avs_writedata[3:0];
    end
  end
  // sticky status and level interrupt
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ist_r     <= 4'h0;
      flags_d_r <= 4'h0;
      irq       <= 1'b0;
    end else begin
      flags_d_r <= flags_r;
      ist_r     <= ist_nxt;
      irq       <= |(ist_r & imsk_r);
    end
  end

  // ------------------------------------------------------------
  // read mux and one-wait handshake
  // ------------------------------------------------------------
  // read data selection by word index
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      pla_pkg::REG_FLAGS:      rd_mux[3:0] = flags_r;
      pla_pkg::REG_INRUSH:     rd_mux[6:0] = inrush_life_r;
      pla_pkg::REG_CTRL_CAP:   rd_mux[6:0] = ctrl_life_r;
      pla_pkg::REG_MAIN_CAP:   rd_mux[6:0] = main_life_r;
      pla_pkg::REG_MEAS_STATE: rd_mux[3:0] = ms_r;
      pla_pkg::REG_OUT_SEL:    rd_mux[7:0] = out_sel_r;
      pla_pkg::REG_IRQ_STAT:   rd_mux[3:0] = ist_r;
      pla_pkg::REG_IRQ_MASK:   rd_mux[3:0] = imsk_r;
      pla_pkg::REG_MAIN_MEAS:  rd_mux[6:0] = main_meas_r;
      default:                 rd_mux = 32'h0000_0000;
    endcase
  end
  // one wait cycle per access; ack_r blocks a second take
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r           <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      ack_r           <= acc;
      avs_waitrequest <= ~acc;
    end
  end
  // read data captured on the take edge, held until the next read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc && avs_read) begin
      avs_readdata <= rd_mux;
    end
  end
endmodule // pla_monitor

// file: verif/pla_monitor_properties.sv
// checker for the life alarm monitor, watching its top-level ports only
// assumes one clock domain, async active-low rstn, bound from the testbench
module pla_monitor_properties #(
  parameter int N_FANS    = 2,
  parameter int DC_CYCLES = 20
) (
  input wire logic              clk,
  input wire logic              rstn,
  input wire logic              avs_read,
  input wire logic              avs_write,
  input wire logic [31:0]       avs_readdata,
  input wire logic              avs_waitrequest,
  input wire logic [N_FANS-1:0] fan_slow,
  input wire logic              power_off,
  input wire logic              run_cmd,
  input wire logic              dc_apply,
  input wire logic              fan_fault_indication
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ------------------------------------------------------------
  // length of the current dc burst
  // ------------------------------------------------------------
  logic [31:0] dc_run_r;
  logic [31:0] dc_run_nxt;
  assign dc_run_nxt = dc_apply ? dc_run_r + 32'h1 : 32'h0;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) dc_run_r <= 32'h0;
    else dc_run_r <= dc_run_nxt;
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  a_wait_one_cycle: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest did not drop one cycle after a request");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest stayed low for more than one cycle");
  a_read_upper_zero: assert property (
    !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_fan_flag_set: assert property (
    $rose(|fan_slow) |-> ##[1:5] fan_fault_indication)
    else $error("fan fault indication missing after a slow fan");
  a_fan_flag_hold: assert property (
    fan_fault_indication && !avs_write && !$past(avs_write) && !$past(avs_write, 2)
    |=> fan_fault_indication)
    else $error("fan fault indication dropped without replacement");
  a_dc_needs_off: assert property (
    dc_apply |-> power_off || $past(power_off) || $past(power_off, 2) || $past(power_off, 3))
    else $error("dc applied while power is on");
  a_dc_bounded: assert property (
    dc_run_r <= DC_CYCLES + 4)
    else $error("dc applied longer than the measurement time");
  a_dc_abort: assert property (
    run_cmd && dc_apply |-> ##[1:6] !dc_apply)
    else $error("dc kept on after a run command");
endmodule // pla_monitor_properties

// file: verif/pla_host.sv
// host model: avalon-mm master that reads and writes the monitor registers
// assumes the slave clock and a slave that answers when it is ready
module pla_host (
  input  wire logic        clk,
  output logic      [3:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle from time zero
  initial begin
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0;
  end
  // one access, held until waitrequest low is sampled at an edge
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
endmodule // pla_host

// file: verif/test_part_life_alarm_monitor.sv
// testbench for the life alarm monitor: registers, pins, alarm terminal, irq
// assumes the host model on the register bus; pins driven at rising edges
module test_part_life_alarm_monitor;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DC = 20;
  logic        clk, rstn, contact_on, operating, hot, power_off, run_cmd, meas_fault;
  logic        output_shutoff_input, avs_read, avs_write, avs_waitrequest;
  logic        dc_apply, life_alarm_out, fan_fault_indication, irq;
  logic [1:0]  fan_slow;
  logic [3:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  int          err_count, samples_checked;
  pla_monitor #(.N_FANS(2), .DC_CYCLES(DC), .CTRL_AGE_CYC(10)) i_dut (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .contact_on(contact_on), .operating(operating),
    .hot(hot), .fan_slow(fan_slow), .power_off(power_off), .run_cmd(run_cmd),
    .output_shutoff_input(output_shutoff_input), .meas_fault(meas_fault),
    .dc_apply(dc_apply), .life_alarm_out(life_alarm_out),
    .fan_fault_indication(fan_fault_indication), .irq(irq));
  pla_host i_host (
    .clk(clk), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest));
  // compare, access and closing helpers
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    i_host.xfer(1'b0, a, 32'h0, q);
    chk($sformatf("register %0d", a), e, q);
  endtask
  task automatic wrap_up();
    $display("mismatches %0d, comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // 125 MHz clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // watchdog against a hung access
  initial begin
    repeat (80000) @(posedge clk);
    err_count++;
    wrap_up();
  end
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  initial begin
    {rstn, contact_on, operating, hot, power_off, run_cmd, meas_fault} = 7'h00;
    output_shutoff_input = 1'b0;
    fan_slow = 2'h0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    rc(pla_pkg::REG_FLAGS, 32'h0);
    rc(pla_pkg::REG_INRUSH, 32'h64);
    rc(pla_pkg::REG_CTRL_CAP, 32'h64);
    rc(pla_pkg::REG_MAIN_CAP, 32'h64);
    rc(pla_pkg::REG_MEAS_STATE, 32'h0);
    rc(4'hA, 32'h0);
    wr(pla_pkg::REG_OUT_SEL, 32'hBE);
    repeat (4) @(posedge clk);
    chk("alarm", 32'h1, {31'h0, life_alarm_out});
    wr(pla_pkg::REG_OUT_SEL, 32'h5A);
    fan_slow <= 2'h2;
    repeat (8) @(posedge clk);
    rc(pla_pkg::REG_FLAGS, 32'h4);
    chk("fan fault", 32'h1, {31'h0, fan_fault_indication});
    chk("alarm", 32'h1, {31'h0, life_alarm_out});
    chk("irq", 32'h0, {31'h0, irq});
    rc(pla_pkg::REG_IRQ_STAT, 32'h4);
    wr(pla_pkg::REG_IRQ_MASK, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(pla_pkg::REG_IRQ_STAT, 32'h4);
    repeat (3) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    wr(pla_pkg::REG_OUT_SEL, 32'hBE);
    fan_slow <= 2'h0;
    repeat (8) @(posedge clk);
    chk("alarm", 32'h0, {31'h0, life_alarm_out});
    rc(pla_pkg::REG_FLAGS, 32'h4);
    wr(pla_pkg::REG_REPLACE, 32'h4);
    rc(pla_pkg::REG_FLAGS, 32'h0);
    wr(pla_pkg::REG_OUT_SEL, 32'h5A);
    // inrush closures up to the first percent step
    for (int i = 1; i <= 10000; i++) begin
      @(posedge clk) contact_on <= 1'b1;
      repeat (2) @(posedge clk);
      contact_on <= 1'b0;
      repeat (2) @(posedge clk);
      if (i == 9999) rc(pla_pkg::REG_INRUSH, 32'h64);
    end
    repeat (4) @(posedge clk);
    rc(pla_pkg::REG_INRUSH, 32'h63);
    // main capacitor measurement at 85 percent
    wr(pla_pkg::REG_MAIN_MEAS, 32'h55);
    wr(pla_pkg::REG_MEAS_STATE, 32'h1);
    wr(pla_pkg::REG_MEAS_STATE, 32'h3);
    rc(pla_pkg::REG_MEAS_STATE, 32'h1);
    power_off <= 1'b1;
    repeat (6) @(posedge clk);
    rc(pla_pkg::REG_MEAS_STATE, 32'h2);
    chk("dc apply", 32'h1, {31'h0, dc_apply});
    repeat (DC + 10) @(posedge clk);
    rc(pla_pkg::REG_MEAS_STATE, 32'h3);
    rc(pla_pkg::REG_MAIN_CAP, 32'h55);
    rc(pla_pkg::REG_FLAGS, 32'h2);
    chk("alarm", 32'h1, {31'h0, life_alarm_out});
    power_off <= 1'b0;
    // disturbances: run command, shutoff, measurement fault
    for (int k = 0; k < 3; k++) begin
      wr(pla_pkg::REG_MEAS_STATE, 32'h1);
      power_off <= 1'b1;
      repeat (6) @(posedge clk);
      {meas_fault, output_shutoff_input, run_cmd} <= 3'h1 << k;
      repeat (DC + 10) @(posedge clk);
      rc(pla_pkg::REG_MEAS_STATE, (k == 2) ? 32'h9 : 32'h8);
      {meas_fault, output_shutoff_input, run_cmd, power_off} <= 4'h0;
      repeat (4) @(posedge clk);
    end
    wr(pla_pkg::REG_MEAS_STATE, 32'h0);
    rc(pla_pkg::REG_MEAS_STATE, 32'h0);
    // power back before the end leaves measuring
    wr(pla_pkg::REG_MEAS_STATE, 32'h1);
    power_off <= 1'b1;
    repeat (6) @(posedge clk);
    power_off <= 1'b0;
    repeat (DC + 10) @(posedge clk);
    rc(pla_pkg::REG_MEAS_STATE, 32'h2);
    // control capacitor ageing while operating hot
    {operating, hot} <= 2'h3;
    repeat (1200) @(posedge clk);
    rc(pla_pkg::REG_FLAGS, 32'h3);
    rc(pla_pkg::REG_CTRL_CAP, 32'h0);
    wrap_up();
  end
endmodule // test_part_life_alarm_monitor
bind pla_monitor pla_monitor_properties #(.N_FANS(N_FANS), .DC_CYCLES(DC_CYCLES)) i_props (
  .clk(clk), .rstn(rstn), .avs_read(avs_read), .avs_write(avs_write),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .fan_slow(fan_slow),
  .power_off(power_off), .run_cmd(run_cmd), .dc_apply(dc_apply),
  .fan_fault_indication(fan_fault_indication));
